/* File: shared/swl_pkg.sv */
package swl_pkg;
  localparam int unsigned clk_mhz = 25;
  // Bus timing in microseconds
  localparam int unsigned reset_low_interval_us = 480;
  localparam int unsigned reset_detect_us = 240;
  localparam int unsigned presence_wait_interval_us = 30;
  localparam int unsigned presence_low_us = 120;
  localparam int unsigned slot_delay_us = 15;
  localparam int unsigned slot_low0_us = 60;
  localparam int unsigned slot_low1_us = 5;
  localparam int unsigned slot_total_us = 70;
  localparam int unsigned recovery_us = 2;
  localparam int unsigned program_pulse_us = 480;
  localparam int unsigned reset_high_us = 480;
  // Derived cycle counts
  localparam int unsigned reset_low_cyc = reset_low_interval_us * clk_mhz;
  localparam int unsigned reset_detect_cyc = reset_detect_us * clk_mhz;
  localparam int unsigned presence_wait_cyc = presence_wait_interval_us * clk_mhz;
  localparam int unsigned presence_low_cyc = presence_low_us * clk_mhz;
  localparam int unsigned slot_delay_cyc = slot_delay_us * clk_mhz;
  localparam int unsigned slot_low0_cyc = slot_low0_us * clk_mhz;
  localparam int unsigned slot_low1_cyc = slot_low1_us * clk_mhz;
  localparam int unsigned slot_total_cyc = slot_total_us * clk_mhz;
  localparam int unsigned recovery_cyc = recovery_us * clk_mhz;
  localparam int unsigned program_pulse_cyc = program_pulse_us * clk_mhz;
  localparam int unsigned reset_high_cyc = reset_high_us * clk_mhz;
  localparam int unsigned cnt_w = 14;
  // CRC constants
  localparam logic [15:0] crc16_poly_rev = 16'ha001;
  localparam logic [7:0] crc8_poly_rev = 8'h8c;
  localparam logic [15:0] crc16_clear = 16'h0000;
  // CRC control codes
  typedef enum logic [1:0] {
    swl_crc_hold = 2'h0,
    swl_crc_clear = 2'h1,
    swl_crc_load = 2'h2
  } swl_crc_op_t;
  // Host command codes
  typedef enum logic [2:0] {
    swl_cmd_reset = 3'h0,
    swl_cmd_write = 3'h1,
    swl_cmd_read = 3'h2,
    swl_cmd_program = 3'h3
  } swl_cmd_t;
endpackage

/* File: shared/swl_if.sv */
`timescale 1ns/1ps
interface swl_if;
  logic host_oe;
  logic dev_oe;
  logic prog_hv;
  logic line;
  // Open-drain wire with pull-up
  assign line = ~(host_oe | dev_oe);
  modport device (input line, input prog_hv, output dev_oe);
  modport host (input line, output host_oe, output prog_hv);
endinterface

/* File: src/swl_device.sv */
`timescale 1ns/1ps
// Overview of operation
// - Only presence pulse starts from device
// - Master resets with 480 us low
// - Wait 15-60 us, presence low 60-240
// - Stealth mode: one presence at power-up
// - Falling edge restarts slot delay timer
// - Write slot sampled after internal delay
// - Read zero holds line low delay
// - Program pulse commits scratchpad byte
// - Master drives 12 V for 480 us
// - Master checks CRC before programming; swl_host starts the program pulse with no CRC check
// - Identity top byte is CRC8, uninverted
// - CRC16 sent complemented
// - Memory read CRC covers all bytes
// - Status read CRC ends at page
// - Extended read: CRC after link byte
// - Extended read: page data CRC cleared
// - First write pass clears then shifts
// - Later write pass loads incremented address
// - CRC mismatch never blocks commands
// - Master keeps reset below 5 ms
module swl_device
  import swl_pkg::*;
#(
  parameter logic [55:0] ID_LOW = 56'h00000000000001 // Arbitrary identity value
) (
  input wire logic clk,
  input wire logic rst,
  swl_if.device bus,
  input wire logic stealth_mode,
  input wire logic tx_bit,
  input wire logic tx_is_crc,
  input wire logic [3:0] tx_crc_idx,
  input wire logic [1:0] crc_op,
  input wire logic [15:0] crc_load_val,
  input wire logic crc_en,
  input wire logic [7:0] scratch_in,
  input wire logic scratch_load,
  output logic reset_seen,
  output logic rx_valid,
  output logic rx_bit,
  output logic tx_taken,
  output logic prog_strobe,
  output logic [7:0] prog_byte,
  output logic [15:0] crc_reg,
  output logic [7:0] id_crc
);
  // Longest count must fit the shared interval counter
  if (reset_detect_cyc >= (1 << cnt_w) || presence_low_cyc >= (1 << cnt_w)) begin : g_cnt_check
    $error("bus timing counts exceed the counter width");
  end
  typedef enum logic [4:0] {
    st_idle = 5'h01,
    st_low = 5'h02,
    st_pwait = 5'h04,
    st_pres = 5'h08,
    st_recov = 5'h10
  } swl_dev_st_t;
  swl_dev_st_t st_reg;
  logic [2:0] sync_reg;
  logic [2:0] hv_sync_reg;
  logic line_s, line_prev_reg, hv_prev_reg;
  logic [cnt_w-1:0] cnt_reg;
  logic pres_done_reg, drive_reg, bit_reg;
  logic [7:0] scratch_reg;
  logic [15:0] crc_next;
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_reg <= 3'h7;
      hv_sync_reg <= 3'h0;
    end else begin
      sync_reg <= {sync_reg[1:0], bus.line};
      hv_sync_reg <= {hv_sync_reg[1:0], bus.prog_hv};
    end
  end
  // Change counts once second and third stages agree
  always_ff @(posedge clk) begin
    if (rst) begin
      line_prev_reg <= 1'b1;
      hv_prev_reg <= 1'b0;
    end else begin
      if (sync_reg[1] == sync_reg[2]) line_prev_reg <= sync_reg[2];
      if (hv_sync_reg[1] == hv_sync_reg[2]) hv_prev_reg <= hv_sync_reg[2];
    end
  end
  assign line_s = line_prev_reg;
  logic fall, rise;
  assign fall = line_prev_reg && (sync_reg[1] == sync_reg[2]) && !sync_reg[2];
  assign rise = !line_prev_reg && (sync_reg[1] == sync_reg[2]) && sync_reg[2];
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= st_idle;
      cnt_reg <= '0;
      pres_done_reg <= 1'b0;
      drive_reg <= 1'b0;
      bit_reg <= 1'b1;
      reset_seen <= 1'b0;
      rx_valid <= 1'b0;
      rx_bit <= 1'b0;
      tx_taken <= 1'b0;
    end else begin
      reset_seen <= 1'b0;
      rx_valid <= 1'b0;
      tx_taken <= 1'b0;
      unique case (st_reg)
        st_idle: begin
          if (fall) begin
            st_reg <= st_low;
            cnt_reg <= '0;
            // Sent CRC bits go out complemented
            bit_reg <= tx_is_crc ? !crc_reg[tx_crc_idx] : tx_bit;
            drive_reg <= tx_is_crc ? crc_reg[tx_crc_idx] : !tx_bit;
            tx_taken <= 1'b1;
          end
        end
        st_low: begin
          if (cnt_reg != cnt_w'(reset_detect_cyc)) cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == cnt_w'(slot_delay_cyc)) begin
            drive_reg <= 1'b0;
            rx_bit <= line_s;
            rx_valid <= 1'b1;
          end
          if (rise) begin
            if (cnt_reg >= cnt_w'(reset_detect_cyc)) begin
              cnt_reg <= '0;
              reset_seen <= 1'b1;
              // Stealth after power-up presence stays silent
              if (stealth_mode && pres_done_reg) st_reg <= st_idle;
              else st_reg <= st_pwait;
            end else if (cnt_reg >= cnt_w'(slot_delay_cyc)) begin
              cnt_reg <= '0;
              st_reg <= st_idle;
            end else begin
              // Short low: keep counting, the sample is still due
              st_reg <= st_recov;
            end
          end
        end
        st_pwait: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == cnt_w'(presence_wait_cyc)) begin
            cnt_reg <= '0;
            drive_reg <= 1'b1;
            st_reg <= st_pres;
          end
        end
        st_pres: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == cnt_w'(presence_low_cyc)) begin
            drive_reg <= 1'b0;
            pres_done_reg <= 1'b1;
            cnt_reg <= '0;
            st_reg <= st_idle;
          end
        end
        st_recov: begin
          // Line already back high; sample at the same delay as a long low
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == cnt_w'(slot_delay_cyc)) begin
            drive_reg <= 1'b0;
            rx_bit <= line_s;
            rx_valid <= 1'b1;
            st_reg <= st_idle;
            cnt_reg <= '0;
          end
        end
        default: st_reg <= st_idle;
      endcase
    end
  end
  assign bus.dev_oe = drive_reg;
  // Program pulse edge commits scratchpad
  always_ff @(posedge clk) begin
    if (rst) begin
      scratch_reg <= 8'h00;
      prog_strobe <= 1'b0;
      prog_byte <= 8'h00;
    end else begin
      prog_strobe <= 1'b0;
      if (scratch_load) scratch_reg <= scratch_in;
      if (hv_sync_reg[1] == hv_sync_reg[2] && hv_sync_reg[2] && !hv_prev_reg) begin
        prog_strobe <= 1'b1;
        prog_byte <= scratch_reg;
      end
    end
  end
  // CRC16 on each received bus bit except sent CRC bits, no blocking on mismatch
  always_comb begin
    crc_next = crc_reg;
    if (crc_reg[0] ^ (tx_is_crc ? 1'b0 : (rx_valid ? rx_bit : bit_reg)))
      crc_next = (crc_reg >> 1) ^ crc16_poly_rev;
    else
      crc_next = crc_reg >> 1;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      crc_reg <= crc16_clear;
    end else if (crc_op == swl_crc_clear) begin
      crc_reg <= crc16_clear;
    end else if (crc_op == swl_crc_load) begin
      crc_reg <= crc_load_val;
    end else if (crc_en && rx_valid && !tx_is_crc) begin
      crc_reg <= crc_next;
    end
  end
  // Identity check value over low 56 bits
  function automatic logic [7:0] crc8_of(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) begin
      if (c[0] ^ d[i]) c = (c >> 1) ^ crc8_poly_rev;
      else c = c >> 1;
    end
    return c;
  endfunction
  assign id_crc = crc8_of(56'(ID_LOW));
endmodule

/* File: src/swl_host.sv */
`timescale 1ns/1ps
module swl_host
  import swl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  swl_if.host bus,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd,
  input wire logic wr_bit,
  output logic cmd_ready,
  output logic done,
  output logic rd_bit,
  output logic presence
);
  typedef enum logic [3:0] {
    hs_idle = 4'h1,
    hs_low = 4'h2,
    hs_rel = 4'h4,
    hs_hv = 4'h8
  } swl_host_st_t;
  swl_host_st_t st_reg;
  swl_cmd_t cmd_reg;
  logic [13:0] cnt_reg;
  logic [13:0] low_len, tot_len;
  logic [2:0] sync_reg;
  logic drive_reg, hv_reg, bit_reg;
  always_ff @(posedge clk) begin
    if (rst) sync_reg <= 3'h7;
    else sync_reg <= {sync_reg[1:0], bus.line};
  end
  always_comb begin
    low_len = 14'(slot_low1_cyc);
    tot_len = 14'(slot_total_cyc);
    unique case (cmd_reg)
      swl_cmd_reset: begin
        low_len = 14'(reset_low_cyc);
        tot_len = 14'(reset_high_cyc);
      end
      swl_cmd_write: low_len = bit_reg ? 14'(slot_low1_cyc) : 14'(slot_low0_cyc);
      swl_cmd_read: low_len = 14'(slot_low1_cyc);
      swl_cmd_program: begin
        low_len = 14'(program_pulse_cyc);
        tot_len = 14'(recovery_cyc);
      end
      default: low_len = 14'(slot_low1_cyc);
    endcase
  end
  assign cmd_ready = (st_reg == hs_idle);
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= hs_idle;
      cmd_reg <= swl_cmd_read;
      cnt_reg <= '0;
      drive_reg <= 1'b0;
      hv_reg <= 1'b0;
      bit_reg <= 1'b1;
      done <= 1'b0;
      rd_bit <= 1'b1;
      presence <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (st_reg)
        hs_idle: if (cmd_valid) begin
          cmd_reg <= swl_cmd_t'(cmd);
          bit_reg <= wr_bit;
          cnt_reg <= '0;
          if (swl_cmd_t'(cmd) == swl_cmd_program) begin
            hv_reg <= 1'b1;
            st_reg <= hs_hv;
          end else begin
            drive_reg <= 1'b1;
            st_reg <= hs_low;
            if (swl_cmd_t'(cmd) == swl_cmd_reset) presence <= 1'b0;
          end
        end
        hs_low: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == low_len) begin
            drive_reg <= 1'b0;
            cnt_reg <= '0;
            st_reg <= hs_rel;
          end
        end
        hs_rel: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cmd_reg == swl_cmd_read && cnt_reg == 14'(slot_delay_cyc / 2))
            rd_bit <= sync_reg[2];
          // Own release is still in the synchroniser for a few cycles
          if (cmd_reg == swl_cmd_reset && cnt_reg > 14'(recovery_cyc) && !sync_reg[2])
            presence <= 1'b1;
          if (cnt_reg == tot_len) begin
            done <= 1'b1;
            st_reg <= hs_idle;
          end
        end
        hs_hv: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == low_len) begin
            hv_reg <= 1'b0;
            cnt_reg <= '0;
            st_reg <= hs_rel;
          end
        end
        default: st_reg <= hs_idle;
      endcase
    end
  end
  assign bus.host_oe = drive_reg;
  assign bus.prog_hv = hv_reg;
endmodule

/* File: testbench/swl_properties.sv */
`timescale 1ns/1ps
module swl_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic host_oe,
  input wire logic dev_oe,
  input wire logic prog_hv,
  input wire logic line
);
  logic [16:0] lo_cnt;
  logic [13:0] hi_cnt;
  logic [13:0] dlo_cnt;
  logic [13:0] hv_cnt;
  logic dev_q;
  logic pres_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk) begin
    lo_cnt <= (rst || !host_oe) ? 17'h0 : lo_cnt + 17'h1;
  end
  // Saturates high so the first slot after reset counts as recovered
  always_ff @(posedge clk) begin
    if (rst) hi_cnt <= 14'h3fff;
    else if (!line) hi_cnt <= 14'h0;
    else if (hi_cnt != 14'h3fff) hi_cnt <= hi_cnt + 14'h1;
  end
  always_ff @(posedge clk) begin
    dlo_cnt <= (rst || !dev_oe) ? 14'h0 : dlo_cnt + 14'h1;
  end
  always_ff @(posedge clk) begin
    hv_cnt <= (rst || !prog_hv) ? 14'h0 : hv_cnt + 14'h1;
  end
  // Presence is the only device drive that starts on a released line
  always_ff @(posedge clk) begin
    dev_q <= rst ? 1'b0 : dev_oe;
    pres_reg <= rst ? 1'b0 : ((dev_oe && !dev_q) ? !host_oe : pres_reg);
  end
  chk_pres_wait_min: assert property ($rose(dev_oe) |-> host_oe || hi_cnt >= 375)
    else $error("device drove released line too early");
  chk_pres_wait_max: assert property ($rose(dev_oe) && !host_oe |-> hi_cnt <= 1500)
    else $error("presence started too late");
  chk_pres_len: assert property ($fell(dev_oe) && pres_reg |-> dlo_cnt inside {[1500:6000]})
    else $error("presence length out of range");
  chk_read_hold: assert property ($fell(dev_oe) && !pres_reg |-> dlo_cnt inside {[300:450]})
    else $error("read zero hold length wrong");
  chk_host_low_len: assert property ($fell(host_oe) |->
      lo_cnt inside {[25:375], [1500:3000], [12000:125000]})
    else $error("host low time out of range");
  chk_slot_recovery: assert property ($rose(host_oe) |-> hi_cnt >= 25)
    else $error("slot started without recovery");
  chk_prog_len: assert property ($fell(prog_hv) |-> $past(hv_cnt) >= 12000)
    else $error("program pulse too short");
  chk_prog_quiet: assert property (prog_hv |-> !dev_oe)
    else $error("device drove during program pulse");
  cov_presence: cover property ($fell(dev_oe) && pres_reg);
  cov_read_zero: cover property ($fell(dev_oe) && !pres_reg);
  cov_program: cover property ($fell(prog_hv));
  cov_reset: cover property ($fell(host_oe) && lo_cnt >= 12000);
endmodule

/* File: testbench/single_wire_slot_and_crc_unit_test.sv */
`timescale 1ns/1ps
module single_wire_slot_and_crc_unit_test;
  import swl_pkg::*;
  typedef struct packed {logic [2:0] c; logic b; logic e;} swl_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic stealth_mode = 1'b0;
  logic tx_bit = 1'b1;
  logic tx_is_crc = 1'b0;
  logic [3:0] tx_crc_idx = 4'h0;
  int resets_seen = 0;
  int slots_seen = 0;
  int slots_exp = 0;
  logic crc_en = 1'b0;
  logic scratch_load = 1'b0;
  logic cmd_valid = 1'b0;
  logic wr_bit = 1'b0;
  logic [1:0] crc_op = 2'h0;
  logic [15:0] crc_load_val = 16'h0;
  logic [7:0] scratch_in = 8'h0;
  logic [2:0] cmd = 3'h0;
  logic reset_seen, rx_valid, rx_bit, tx_taken, prog_strobe, cmd_ready, done, rd_bit, presence;
  logic [7:0] prog_byte;
  logic [7:0] id_crc;
  logic [15:0] crc_reg;
  logic last_rx = 1'b0;
  logic [7:0] got_byte = 8'h0;
  int errors = 0;
  int check_count = 0;
  swl_row_t rows [4] = '{'{3'h1, 1'b1, 1'b1}, '{3'h1, 1'b0, 1'b0},
                         '{3'h2, 1'b0, 1'b0}, '{3'h2, 1'b1, 1'b1}};
  swl_if bus_if();
  always #20 clk = ~clk;
  swl_device i_swl_device (.clk(clk), .rst(rst), .bus(bus_if), .stealth_mode(stealth_mode),
    .tx_bit(tx_bit), .tx_is_crc(tx_is_crc), .tx_crc_idx(tx_crc_idx), .crc_op(crc_op),
    .crc_load_val(crc_load_val), .crc_en(crc_en), .scratch_in(scratch_in),
    .scratch_load(scratch_load), .reset_seen(reset_seen), .rx_valid(rx_valid), .rx_bit(rx_bit),
    .tx_taken(tx_taken), .prog_strobe(prog_strobe), .prog_byte(prog_byte), .crc_reg(crc_reg),
    .id_crc(id_crc));
  swl_host i_swl_host (.clk(clk), .rst(rst), .bus(bus_if), .cmd_valid(cmd_valid), .cmd(cmd),
    .wr_bit(wr_bit), .cmd_ready(cmd_ready), .done(done), .rd_bit(rd_bit), .presence(presence));
  swl_properties i_swl_properties (.clk(clk), .rst(rst), .host_oe(bus_if.host_oe),
    .dev_oe(bus_if.dev_oe), .prog_hv(bus_if.prog_hv), .line(bus_if.line));
  always @(posedge clk) if (rx_valid === 1'b1) last_rx <= rx_bit;
  always @(posedge clk) if (prog_strobe === 1'b1) got_byte <= prog_byte;
  always @(posedge clk) if (reset_seen === 1'b1) resets_seen++;
  always @(posedge clk) if (tx_taken === 1'b1) slots_seen++;
  function automatic logic [15:0] c16(input logic [15:0] c, input logic b);
    return (c[0] ^ b) ? ((c >> 1) ^ crc16_poly_rev) : (c >> 1);
  endfunction
  function automatic logic [7:0] c8(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h0;
    for (int i = 0; i < 56; i++) c = (c[0] ^ d[i]) ? ((c >> 1) ^ crc8_poly_rev) : (c >> 1);
    return c;
  endfunction
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One command at a time; the next waits for done
  task automatic do_cmd(input logic [2:0] c, input logic w);
    int n;
    n = 0;
    if (c != swl_cmd_program) slots_exp++;
    cmd = c;
    wr_bit = w;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    if (n >= 100) begin
      errors++;
      stop_test();
    end
    tick(1);
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40000) begin
      tick(1);
      n++;
    end
    if (n >= 40000) begin
      errors++;
      stop_test();
    end
  endtask
  initial begin
    logic [7:0] d;
    logic [15:0] exp;
    d = 8'hf7;
    exp = crc16_clear;
    tick(8);
    rst = 1'b0;
    check("id_crc", {8'h0, id_crc}, {8'h0, c8(56'h1)});
    tick(1);
    foreach (rows[i]) begin
      tx_bit = rows[i].b;
      do_cmd(rows[i].c, rows[i].b);
      check("slot_bit", {15'h0, (rows[i].c == 3'h1) ? last_rx : rd_bit}, {15'h0, rows[i].e});
    end
    tx_bit = 1'b1;
    crc_en = 1'b1;
    crc_load_val = 16'h1234;
    crc_op = swl_crc_load;
    tick(1);
    crc_op = swl_crc_hold;
    check("crc_load", crc_reg, 16'h1234);
    // Send two CRC bits; each must leave complemented and not shift the CRC
    tx_is_crc = 1'b1;
    tx_crc_idx = 4'h2;
    do_cmd(swl_cmd_read, 1'b1);
    check("crc_tx_bit", {15'h0, rd_bit}, {15'h0, ~crc_load_val[tx_crc_idx]});
    tx_crc_idx = 4'h0;
    do_cmd(swl_cmd_read, 1'b1);
    check("crc_tx_bit", {15'h0, rd_bit}, {15'h0, ~crc_load_val[tx_crc_idx]});
    tx_is_crc = 1'b0;
    check("crc_hold_tx", crc_reg, 16'h1234);
    do_cmd(swl_cmd_write, 1'b1);
    check("crc_after_load", crc_reg, c16(16'h1234, 1'b1));
    crc_op = swl_crc_clear;
    tick(1);
    crc_op = swl_crc_hold;
    check("crc_clear", crc_reg, crc16_clear);
    for (int i = 0; i < 8; i++) begin
      do_cmd(swl_cmd_write, d[i]);
      exp = c16(exp, d[i]);
    end
    check("crc_shift", crc_reg, exp);
    crc_en = 1'b0;
    scratch_in = 8'h5a;
    scratch_load = 1'b1;
    tick(1);
    scratch_load = 1'b0;
    do_cmd(swl_cmd_program, 1'b0);
    check("prog_byte", {8'h0, got_byte}, 16'h005a);
    // Second reset mid-run with stealth power-up selected
    stealth_mode = 1'b1;
    rst = 1'b1;
    tick(8);
    rst = 1'b0;
    tick(1);
    do_cmd(swl_cmd_reset, 1'b0);
    check("presence_first", {15'h0, presence}, 16'h1);
    do_cmd(swl_cmd_reset, 1'b0);
    check("presence_later", {15'h0, presence}, 16'h0);
    check("reset_seen", 16'(resets_seen), 16'h2);
    check("slot_starts", 16'(slots_seen), 16'(slots_exp));
    stop_test();
  end
  initial begin
    #(100000 * 40);
    errors++;
    stop_test();
  end
endmodule
